// *** hdl/ctps_pkg.sv ***
// constants and carrier types for the cpu timer prescaler
//
// Functional notes
// - count above zero decrements every source cycle
// - after zero: reload divide value, emit tick
// - reload strobe write loads count from divide
// - count fields read only, writes ignored
// - reset clears the 16-bit prescale count
// - divide writable; tick every divide+1 cycles
// - reset clears the 16-bit divide value
// - high register holds upper count and divide
// - reload strobe reads zero, zero write ignored
// - halt bit one stops, zero restarts
package ctps_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STRB_W = 4;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PRESCALE_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int PRESCALE_W = 16;
  localparam int HALF_W = 8;
  localparam int BIT_RELOAD = 5;
  localparam int BIT_HALT = 4;
  localparam int LANE_DIVIDE = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [PRESCALE_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PRESCALE_W-1:0] DIVIDE_RST = 16'h0000;
  localparam logic HALT_RST = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // apb carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } ctps_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ctps_apb_rsp_t;

endpackage

// *** hdl/ctps_down_counter.sv ***
// prescale down counter with expiry reload and tick
`timescale 1ns/10ps
module ctps_down_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // state
  output logic [WIDTH-1:0] count,
  output logic tick
);
  import ctps_pkg::*;

  logic [WIDTH-1:0] next_count;
  logic next_tick;

  // next count: load wins, then expiry reload, then decrement
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (load) begin
      next_count = loadValue;
    end else if (run) begin
      if (count != '0) begin
        next_count = count - WIDTH'(1);
      end else begin
        next_count = loadValue;
        next_tick = 1'b1;
      end
    end
  end

  // register the count and the tick pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

// *** hdl/ctps_prescaler.sv ***
// cpu timer prescaler with apb register slave
`timescale 1ns/10ps
module ctps_prescaler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire ctps_pkg::ctps_apb_req_t apbReq,
  output ctps_pkg::ctps_apb_rsp_t apbRsp,
  // timer side
  output logic mainDecTick,
  output logic timerHalt,
  output logic [ctps_pkg::PRESCALE_W-1:0] prescaleCount
);
  import ctps_pkg::*;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic hitLow;
  logic hitHigh;
  logic hitCtrl;
  logic hitAny;
  logic divLane;

  // request phases and address hits
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign wrAccess = accessPhase && apbReq.pwrite;
  assign hitLow = apbReq.paddr == OFS_PRESCALE_LOW;
  assign hitHigh = apbReq.paddr == OFS_PRESCALE_HIGH;
  assign hitCtrl = apbReq.paddr == OFS_CONTROL;
  assign hitAny = hitLow || hitHigh || hitCtrl;
  assign divLane = apbReq.pstrb[LANE_DIVIDE];

  // ---------------------------------------------------------------
  // software state: divide value and halt bit
  // ---------------------------------------------------------------
  logic [PRESCALE_W-1:0] divide;
  logic [PRESCALE_W-1:0] next_divide;
  logic next_timerHalt;
  logic reloadPulse;
  logic divideWrite;

  // writes land on the access edge; count fields take no write
  always_comb begin
    next_divide = divide;
    next_timerHalt = timerHalt;
    divideWrite = 1'b0;
    reloadPulse = 1'b0;
    if (wrAccess && divLane) begin
      if (hitLow) begin
        next_divide[HALF_W-1:0] = apbReq.pwdata[HALF_W-1:0];
        divideWrite = 1'b1;
      end
      if (hitHigh) begin
        next_divide[PRESCALE_W-1:HALF_W] = apbReq.pwdata[HALF_W-1:0];
        divideWrite = 1'b1;
      end
      if (hitCtrl) begin
        next_timerHalt = apbReq.pwdata[BIT_HALT];
        reloadPulse = apbReq.pwdata[BIT_RELOAD];
      end
    end
  end

  // register divide and halt
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      divide <= DIVIDE_RST;
      timerHalt <= HALT_RST;
    end else begin
      divide <= next_divide;
      timerHalt <= next_timerHalt;
    end
  end

  // ---------------------------------------------------------------
  // prescale counter
  // ---------------------------------------------------------------
  // counter stalls while halted, reload still takes the current divide
  ctps_down_counter #(
    .WIDTH(PRESCALE_W)
  ) uCounter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(!timerHalt),
    .load(reloadPulse),
    .loadValue(divide),
    .count(prescaleCount),
    .tick(mainDecTick)
  );

  // ---------------------------------------------------------------
  // read data and error
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic rdErr;
  logic next_rdErr;

  // read value captured in the setup cycle, stable through access
  always_comb begin
    next_rdata = rdata;
    next_rdErr = rdErr;
    if (setupPhase) begin
      next_rdata = RDATA_RST;
      next_rdErr = !hitAny;
      if (!apbReq.pwrite) begin
        if (hitLow) begin
          next_rdata[PRESCALE_W-1:0] = {prescaleCount[HALF_W-1:0], divide[HALF_W-1:0]};
        end
        if (hitHigh) begin
          next_rdata[PRESCALE_W-1:0] = {prescaleCount[PRESCALE_W-1:HALF_W],
                                        divide[PRESCALE_W-1:HALF_W]};
        end
        if (hitCtrl) begin
          next_rdata[BIT_HALT] = timerHalt;
        end
      end
    end
  end

  // register read data and error flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= RDATA_RST;
      rdErr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdErr <= next_rdErr;
    end
  end

  // zero wait state answer
  assign apbRsp.prdata = rdata;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = accessPhase && rdErr;

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  logic resetSeen;
  logic dirty;
  logic [PRESCALE_W:0] gapCount;
  logic [PRESCALE_W-1:0] periodLoad;

  // gap between ticks and the count loaded at the last tick, dirty when disturbed
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resetSeen <= 1'b0;
      dirty <= 1'b1;
      gapCount <= '0;
      periodLoad <= '0;
    end else begin
      resetSeen <= 1'b1;
      if (mainDecTick) begin
        gapCount <= (PRESCALE_W+1)'(1);
        periodLoad <= prescaleCount; // value loaded at the expiry that raised this tick
      end else if (gapCount != '1) begin
        gapCount <= gapCount + (PRESCALE_W+1)'(1);
      end
      if (reloadPulse || timerHalt || divideWrite) begin
        dirty <= 1'b1;
      end else if (mainDecTick) begin
        dirty <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence seqCtrlWrite;
    wrAccess && divLane && hitCtrl;
  endsequence

  sequence seqCtrlRead;
    setupPhase && !apbReq.pwrite && hitCtrl;
  endsequence

  AST_DECREMENT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!timerHalt && !reloadPulse && prescaleCount != '0) |=>
      prescaleCount == $past(prescaleCount) - PRESCALE_W'(1) && !mainDecTick)
    else $error("prescale count did not decrement");

  AST_EXPIRE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!timerHalt && !reloadPulse && prescaleCount == '0) |=>
      prescaleCount == $past(divide) && mainDecTick ##1 (!mainDecTick || $past(prescaleCount) == '0))
    else $error("expiry did not reload and tick once");

  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reloadPulse |=> prescaleCount == $past(divide) && !mainDecTick)
    else $error("reload strobe did not load the count");

  AST_COUNT_SOURCE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !$stable(prescaleCount) |-> $past(!timerHalt || reloadPulse))
    else $error("count changed without counting or reload");

  AST_COUNT_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !resetSeen |-> prescaleCount == COUNT_RST)
    else $error("count not cleared by reset");

  AST_PERIOD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (mainDecTick && !dirty && !reloadPulse) |-> gapCount == {1'b0, periodLoad} + (PRESCALE_W+1)'(1))
    else $error("tick period differs from divide plus one");

  AST_DIVIDE_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !resetSeen |-> divide == DIVIDE_RST && !timerHalt)
    else $error("divide not cleared by reset");

  AST_HIGH_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (setupPhase && !apbReq.pwrite && hitHigh) |=>
      apbRsp.prdata == {16'h0000, $past(prescaleCount[PRESCALE_W-1:HALF_W]),
                        $past(divide[PRESCALE_W-1:HALF_W])})
    else $error("high register read mismatch");

  AST_RELOAD_READS_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    seqCtrlRead |=> apbRsp.prdata[BIT_RELOAD] == 1'b0 && apbRsp.prdata[BIT_HALT] == $past(timerHalt))
    else $error("control read shows reload bit set");

  AST_HALT_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    seqCtrlWrite |=> timerHalt == $past(apbReq.pwdata[BIT_HALT]))
    else $error("halt bit did not follow the write");

  AST_HALT_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (timerHalt && !reloadPulse) |=> $stable(prescaleCount) ##0 !mainDecTick)
    else $error("counter moved while halted");

endmodule

// *** tb/ctps_prescaler_tb.sv ***
// self-checking bench for the cpu timer prescaler
`timescale 1ns/10ps
module ctps_prescaler_tb;
  import ctps_pkg::*;

  // ---------------------------------------------------------------
  // stimulus, observation and bookkeeping
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  ctps_apb_req_t apbReq = '0;
  ctps_apb_rsp_t apbRsp;
  logic mainDecTick;
  logic timerHalt;
  logic [PRESCALE_W-1:0] prescaleCount;
  logic [DATA_W-1:0] rdata;
  logic rerr;
  logic [PRESCALE_W-1:0] snapA;
  int gap;
  int failures = 0;
  int numChecks = 0;

  // 20 mhz system clock
  always #25 clk_sys = ~clk_sys;

  // design under test
  ctps_prescaler uut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .mainDecTick(mainDecTick),
    .timerHalt(timerHalt),
    .prescaleCount(prescaleCount)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // compare one observed value with its expectation
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // print counts and verdict, then end the run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer started after a rising edge, held until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [STRB_W-1:0] st);
    @(posedge clk_sys);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    apbReq.pstrb <= st;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    @(posedge clk_sys);
    while (apbRsp.pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdata = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // full-word write and read shorthands
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  // cycles from now until the next tick, bounded
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (mainDecTick !== 1'b1 && k < 1000);
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    // everything comes out of reset cleared
    rd(OFS_PRESCALE_LOW);
    check(rdata, 32'h0000_0000);
    rd(OFS_PRESCALE_HIGH);
    check(rdata, 32'h0000_0000);
    rd(OFS_CONTROL);
    check(rdata, 32'h0000_0000);
    // default divide of zero ticks on every cycle
    repeat (4) begin
      @(negedge clk_sys);
      check({31'h0000_0000, mainDecTick}, 32'h0000_0001);
    end
    // unmapped address answers with an error and zero data
    rd(8'h0c);
    check({rdata[30:0], rerr}, 32'h0000_0001);
    // divide of three gives a period of four
    wr(OFS_PRESCALE_LOW, 32'h0000_0003);
    wait_tick(gap);
    wait_tick(gap);
    check(gap, 32'h0000_0004);
    check({16'h0000, prescaleCount}, 32'h0000_0003);
    @(negedge clk_sys);
    check({16'h0000, prescaleCount}, 32'h0000_0002);
    // halt, set a 16-bit divide and reload while stopped
    wr(OFS_CONTROL, 32'h0000_0010);
    check({31'h0000_0000, timerHalt}, 32'h0000_0001);
    wr(OFS_PRESCALE_HIGH, 32'h0000_0001);
    wr(OFS_PRESCALE_LOW, 32'h0000_0005);
    wr(OFS_CONTROL, 32'h0000_0030);
    check({16'h0000, prescaleCount}, 32'h0000_0105);
    rd(OFS_PRESCALE_LOW);
    check(rdata, 32'h0000_0505);
    rd(OFS_PRESCALE_HIGH);
    check(rdata, 32'h0000_0101);
    // count field ignores writes; a write without strobe changes nothing
    wr(OFS_PRESCALE_LOW, 32'h0000_ff07);
    apb(1'b1, OFS_PRESCALE_LOW, 32'h0000_0009, 4'h0);
    rd(OFS_PRESCALE_LOW);
    check(rdata, 32'h0000_0507);
    // writing zero to the reload strobe leaves the count alone
    wr(OFS_CONTROL, 32'h0000_0010);
    check({16'h0000, prescaleCount}, 32'h0000_0105);
    rd(OFS_CONTROL);
    check(rdata, 32'h0000_0010);
    // stopped timer holds its count and emits no tick
    gap = 0;
    repeat (20) begin
      @(negedge clk_sys);
      if (mainDecTick !== 1'b0) gap++;
    end
    check(gap, 32'h0000_0000);
    check({16'h0000, prescaleCount}, 32'h0000_0105);
    // restart resumes counting down by one per cycle
    wr(OFS_CONTROL, 32'h0000_0000);
    check({31'h0000_0000, timerHalt}, 32'h0000_0000);
    @(negedge clk_sys);
    snapA = prescaleCount;
    repeat (5) @(negedge clk_sys);
    check({16'h0000, prescaleCount}, {16'h0000, snapA - 16'h0005});
    // reload while running overrides the count
    wr(OFS_CONTROL, 32'h0000_0020);
    @(negedge clk_sys);
    check({16'h0000, prescaleCount}, 32'h0000_0106);
    rd(OFS_CONTROL);
    check(rdata, 32'h0000_0000);
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    #100_000;
    failures++;
    report_and_stop();
  end
endmodule
